// File: src/pald_decoder.sv
/*
 * Peripheral access latency decoder: decodes each I/O access address into a
 * region, picks the region's cycle count and counting clock, and holds the
 * master waiting until that count has elapsed.
 * Assumes the peripheral clock edges, the ratio flag, the bus grant and the
 * quad-serial busy flag come from logic on clk_in.
 */
// What this block does
// - Fixed cycle count per region, region's clock
// - Latency sums bus, sync and wait cycles
// - Equal clocks give constant sync overhead
// - Faster core adds a peripheral cycle
// - First and third quad window writes end only when target finishes
// - Contention may lengthen accesses
// - Memory and bus control region: two cycles
// - Debug and flash cache: two cycles
// - Lower system control: three core cycles
// - Upper system control: seven slow cycles
// - Port region: three, or four faster
// - Event, watchdog, stop, sound: three slow
// - Low-power timer: read three, write five/six
// - Sensor, CRC, I3C, PDM, converters: three/four
// - Serial regions: base three/four, plus width extra
// - PWM timer: read six/seven, write four/five
// - First quad window: writes thirteen open-ended
// - Second quad window: three or four
// - Third quad window: writes thirteen/fourteen open-ended
// - Final quad window: two or three
// - Fractional ranges round maximum upward
// - Serial comm 16-bit adds two cycles
// - Serial peripheral 32-bit adds two cycles
// - Open writes follow quad bus progress
`timescale 1ns/100ps
`default_nettype none

module pald_decoder (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic access_req_in,
	input wire logic [31:0] access_addr_in,
	input wire logic access_write_in,
	input wire logic [1:0] access_size_in,
	input wire logic bus_grant_in,
	input wire logic core_faster_in,
	input wire logic fast_tick_in,
	input wire logic slow_tick_in,
	input wire logic quad_bus_busy_in,
	output logic access_wait_out,
	output logic access_done_out,
	output logic access_reserved_out,
	output logic [4:0] region_out,
	output logic [pald_pkg::LAT_W-1:0] latency_out
);

	// ==========================================================================
	// Decode functions
	// ==========================================================================
	function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	function automatic pald_pkg::pald_region_e region_of(input logic [31:0] a);
		if (in_range(a, pald_pkg::ADDR_MEM_CTRL_LO, pald_pkg::ADDR_MEM_CTRL_HI)) begin
			region_of = pald_pkg::RG_MEM_CTRL;
		end else if (in_range(a, pald_pkg::ADDR_DEBUG_LO, pald_pkg::ADDR_DEBUG_HI)) begin
			region_of = pald_pkg::RG_DEBUG;
		end else if (in_range(a, pald_pkg::ADDR_SYSCTL_LO_LO, pald_pkg::ADDR_SYSCTL_LO_HI)) begin
			region_of = pald_pkg::RG_SYSCTL_LO;
		end else if (in_range(a, pald_pkg::ADDR_SYSCTL_HI_LO, pald_pkg::ADDR_SYSCTL_HI_HI)) begin
			region_of = pald_pkg::RG_SYSCTL_HI;
		end else if (in_range(a, pald_pkg::ADDR_PORT_LO, pald_pkg::ADDR_PORT_HI)) begin
			region_of = pald_pkg::RG_PORT;
		end else if (in_range(a, pald_pkg::ADDR_EVT_LO, pald_pkg::ADDR_EVT_HI)) begin
			region_of = pald_pkg::RG_EVT;
		end else if (in_range(a, pald_pkg::ADDR_SOUND_LO, pald_pkg::ADDR_SOUND_HI)) begin
			region_of = pald_pkg::RG_SOUND;
		end else if (in_range(a, pald_pkg::ADDR_LPTIM_LO, pald_pkg::ADDR_LPTIM_HI)) begin
			region_of = pald_pkg::RG_LPTIM;
		end else if (in_range(a, pald_pkg::ADDR_TEMP_LO, pald_pkg::ADDR_TEMP_HI)) begin
			region_of = pald_pkg::RG_TEMP;
		end else if (in_range(a, pald_pkg::ADDR_CRC_LO, pald_pkg::ADDR_CRC_HI)) begin
			region_of = pald_pkg::RG_CRC;
		end else if (in_range(a, pald_pkg::ADDR_SERCOM_LO, pald_pkg::ADDR_SERCOM_HI)) begin
			region_of = pald_pkg::RG_SERCOM;
		end else if (in_range(a, pald_pkg::ADDR_SERPER_LO, pald_pkg::ADDR_SERPER_HI)) begin
			region_of = pald_pkg::RG_SERPER;
		end else if (in_range(a, pald_pkg::ADDR_I3C_LO, pald_pkg::ADDR_I3C_HI)) begin
			region_of = pald_pkg::RG_I3C;
		end else if (in_range(a, pald_pkg::ADDR_PDM_LO, pald_pkg::ADDR_PDM_HI)) begin
			region_of = pald_pkg::RG_PDM;
		end else if (in_range(a, pald_pkg::ADDR_PWM_LO, pald_pkg::ADDR_PWM_HI)) begin
			region_of = pald_pkg::RG_PWM;
		end else if (in_range(a, pald_pkg::ADDR_CONV_LO, pald_pkg::ADDR_CONV_HI)) begin
			region_of = pald_pkg::RG_CONV;
		end else if (in_range(a, pald_pkg::ADDR_QUAD0_LO, pald_pkg::ADDR_QUAD0_HI)) begin
			region_of = pald_pkg::RG_QUAD0;
		end else if (in_range(a, pald_pkg::ADDR_QUAD1_LO, pald_pkg::ADDR_QUAD1_HI)) begin
			region_of = pald_pkg::RG_QUAD1;
		end else if (in_range(a, pald_pkg::ADDR_QUAD2_LO, pald_pkg::ADDR_QUAD2_HI)) begin
			region_of = pald_pkg::RG_QUAD2;
		end else if (in_range(a, pald_pkg::ADDR_QUAD3_LO, pald_pkg::ADDR_QUAD3_HI)) begin
			region_of = pald_pkg::RG_QUAD3;
		end else begin
			region_of = pald_pkg::RG_NONE;
		end
	endfunction

	function automatic pald_pkg::pald_unit_e unit_of(input pald_pkg::pald_region_e r);
		case (r)
			pald_pkg::RG_NONE, pald_pkg::RG_MEM_CTRL, pald_pkg::RG_DEBUG,
			pald_pkg::RG_SYSCTL_LO: begin
				unit_of = pald_pkg::UNIT_CORE;
			end
			pald_pkg::RG_SYSCTL_HI, pald_pkg::RG_PORT, pald_pkg::RG_EVT,
			pald_pkg::RG_SOUND, pald_pkg::RG_LPTIM, pald_pkg::RG_TEMP: begin
				unit_of = pald_pkg::UNIT_SLOW;
			end
			default: begin
				unit_of = pald_pkg::UNIT_FAST;
			end
		endcase
	endfunction

	// Picks eq or fast figure; the fast figure is the rounded-up top of the range.
	function automatic logic [pald_pkg::LAT_W-1:0] pick(input logic fast,
		input logic [pald_pkg::LAT_W-1:0] eq, input logic [pald_pkg::LAT_W-1:0] hi);
		pick = fast ? hi : eq;
	endfunction

	function automatic logic [pald_pkg::LAT_W-1:0] base_of(input pald_pkg::pald_region_e r,
		input logic wr, input logic fast);
		case (r)
			pald_pkg::RG_MEM_CTRL: base_of = pald_pkg::LAT_MEM_CTRL;
			pald_pkg::RG_DEBUG: base_of = pald_pkg::LAT_DEBUG;
			pald_pkg::RG_SYSCTL_LO: base_of = pald_pkg::LAT_SYSCTL_LO;
			pald_pkg::RG_SYSCTL_HI: begin
				base_of = pick(fast, pald_pkg::LAT_SYSCTL_HI_EQ, pald_pkg::LAT_SYSCTL_HI_FAST);
			end
			pald_pkg::RG_PORT: base_of = pick(fast, pald_pkg::LAT_PORT_EQ, pald_pkg::LAT_PORT_FAST);
			pald_pkg::RG_EVT, pald_pkg::RG_SOUND: base_of = pald_pkg::LAT_FIXED_SLOW;
			pald_pkg::RG_LPTIM: begin
				base_of = wr ? pick(fast, pald_pkg::LAT_LPTIM_WR_EQ, pald_pkg::LAT_LPTIM_WR_FAST) :
					pald_pkg::LAT_LPTIM_RD;
			end
			pald_pkg::RG_PWM: begin
				base_of = wr ? pick(fast, pald_pkg::LAT_PWM_WR_EQ, pald_pkg::LAT_PWM_WR_FAST) :
					pick(fast, pald_pkg::LAT_PWM_RD_EQ, pald_pkg::LAT_PWM_RD_FAST);
			end
			pald_pkg::RG_QUAD0: begin
				base_of = wr ? pick(fast, pald_pkg::LAT_QUAD_WR_EQ, pald_pkg::LAT_QUAD0_WR_FAST) :
					pick(fast, pald_pkg::LAT_STD_EQ, pald_pkg::LAT_STD_FAST);
			end
			pald_pkg::RG_QUAD2: begin
				base_of = wr ? pick(fast, pald_pkg::LAT_QUAD_WR_EQ, pald_pkg::LAT_QUAD2_WR_FAST) :
					pick(fast, pald_pkg::LAT_STD_EQ, pald_pkg::LAT_STD_FAST);
			end
			pald_pkg::RG_QUAD3: base_of = pick(fast, pald_pkg::LAT_QUAD3_EQ, pald_pkg::LAT_QUAD3_FAST);
			pald_pkg::RG_QUAD1: base_of = pick(fast, pald_pkg::LAT_STD_EQ, pald_pkg::LAT_STD_FAST);
			pald_pkg::RG_SERCOM, pald_pkg::RG_SERPER: begin
				base_of = pick(fast, pald_pkg::LAT_STD_EQ, pald_pkg::LAT_STD_FAST);
			end
			pald_pkg::RG_TEMP, pald_pkg::RG_CRC, pald_pkg::RG_I3C, pald_pkg::RG_PDM,
			pald_pkg::RG_CONV: begin
				base_of = pick(fast, pald_pkg::LAT_STD_EQ, pald_pkg::LAT_STD_FAST);
			end
			default: base_of = pald_pkg::LAT_RESERVED;
		endcase
	endfunction

	// ==========================================================================
	// Request decode
	// ==========================================================================
	pald_pkg::pald_region_e region_w;
	pald_pkg::pald_unit_e unit_w;
	logic [pald_pkg::LAT_W-1:0] base_w;
	logic [pald_pkg::LAT_W-1:0] extra_w;
	logic [pald_pkg::LAT_W-1:0] total_w;
	logic reserved_w;
	logic open_end_w;
	logic start_w;

	assign region_w = region_of(access_addr_in);
	assign unit_w = unit_of(region_w);
	assign base_w = base_of(region_w, access_write_in, core_faster_in);
	// Register width extra cycles for the two serial regions.
	assign extra_w = ((region_w == pald_pkg::RG_SERCOM && access_size_in == pald_pkg::SIZE_HALF) ||
		(region_w == pald_pkg::RG_SERPER && access_size_in == pald_pkg::SIZE_WORD)) ?
		pald_pkg::LAT_WIDTH_EXTRA : '0;
	assign total_w = base_w + extra_w;
	assign reserved_w = (region_w == pald_pkg::RG_NONE);
	assign open_end_w = access_write_in &&
		(region_w == pald_pkg::RG_QUAD0 || region_w == pald_pkg::RG_QUAD2);

	// ==========================================================================
	// Access sequencer
	// ==========================================================================
	pald_pkg::pald_state_e state_r;
	pald_pkg::pald_state_e state_nxt;
	logic open_end_r;
	logic reserved_r;
	logic finish_w;
	pald_pkg::pald_unit_e unit_r;

	pald_tmr_if tmr ();

	// Reserved addresses are still answered, so a stray access cannot hang the bus.
	assign start_w = (state_r == pald_pkg::ST_IDLE) && access_req_in;
	// Open-ended writes stay pending while the quad-serial bus is still busy.
	assign finish_w = (state_r == pald_pkg::ST_RUN) && tmr.expired &&
		!(open_end_r && quad_bus_busy_in);
	assign state_nxt = start_w ? pald_pkg::ST_RUN :
		finish_w ? pald_pkg::ST_IDLE : state_r;

	assign tmr.load = start_w;
	assign tmr.load_count = reserved_w ? pald_pkg::LAT_RESERVED : total_w;
	assign tmr.unit = start_w ? unit_w : unit_r;
	assign tmr.grant = bus_grant_in;
	assign tmr.fast_tick = fast_tick_in;
	assign tmr.slow_tick = slow_tick_in;

	assign access_wait_out = (state_r == pald_pkg::ST_RUN) && !finish_w;
	assign access_done_out = finish_w;
	assign access_reserved_out = finish_w && reserved_r;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= pald_pkg::ST_IDLE;
			open_end_r <= 1'b0;
			reserved_r <= 1'b0;
			unit_r <= pald_pkg::UNIT_CORE;
			region_out <= '0;
			latency_out <= '0;
		end else begin
			state_r <= state_nxt;
			if (start_w) begin
				open_end_r <= open_end_w;
				reserved_r <= reserved_w;
				unit_r <= reserved_w ? pald_pkg::UNIT_CORE : unit_w;
				region_out <= region_w;
				latency_out <= tmr.load_count;
			end
		end
	end

	pald_wait_timer u_timer (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.tmr(tmr)
	);

endmodule // pald_decoder

`default_nettype wire

// File: src/pald_pkg.sv
/*
 * Constants for the peripheral access latency decoder: region address bounds,
 * per-region cycle counts and the region and counting-clock enumerations.
 * Assumes a 32-bit byte address from the requesting bus master.
 */
package pald_pkg;

	// ==========================================================================
	// Region address bounds
	// ==========================================================================
	localparam logic [31:0] ADDR_MEM_CTRL_LO = 32'h4000_0000;
	localparam logic [31:0] ADDR_MEM_CTRL_HI = 32'h4000_6fff;
	localparam logic [31:0] ADDR_DEBUG_LO = 32'h4000_8000;
	localparam logic [31:0] ADDR_DEBUG_HI = 32'h4001_cfff;
	localparam logic [31:0] ADDR_SYSCTL_LO_LO = 32'h4001_e000;
	localparam logic [31:0] ADDR_SYSCTL_LO_HI = 32'h4001_e3ff;
	localparam logic [31:0] ADDR_SYSCTL_HI_LO = 32'h4001_e400;
	localparam logic [31:0] ADDR_SYSCTL_HI_HI = 32'h4001_e5ff;
	localparam logic [31:0] ADDR_PORT_LO = 32'h4008_0000;
	localparam logic [31:0] ADDR_PORT_HI = 32'h4008_0fff;
	localparam logic [31:0] ADDR_EVT_LO = 32'h4008_2000;
	localparam logic [31:0] ADDR_EVT_HI = 32'h4008_4fff;
	localparam logic [31:0] ADDR_SOUND_LO = 32'h4009_d000;
	localparam logic [31:0] ADDR_SOUND_HI = 32'h4009_dfff;
	localparam logic [31:0] ADDR_LPTIM_LO = 32'h400e_8000;
	localparam logic [31:0] ADDR_LPTIM_HI = 32'h400e_8fff;
	localparam logic [31:0] ADDR_TEMP_LO = 32'h400f_3000;
	localparam logic [31:0] ADDR_TEMP_HI = 32'h400f_3fff;
	localparam logic [31:0] ADDR_CRC_LO = 32'h4010_8000;
	localparam logic [31:0] ADDR_CRC_HI = 32'h4010_9fff;
	localparam logic [31:0] ADDR_SERCOM_LO = 32'h4011_8000;
	localparam logic [31:0] ADDR_SERCOM_HI = 32'h4011_8fff;
	localparam logic [31:0] ADDR_SERPER_LO = 32'h4011_a000;
	localparam logic [31:0] ADDR_SERPER_HI = 32'h4011_afff;
	localparam logic [31:0] ADDR_I3C_LO = 32'h4011_f000;
	localparam logic [31:0] ADDR_I3C_HI = 32'h4011_ffff;
	localparam logic [31:0] ADDR_PDM_LO = 32'h4013_1000;
	localparam logic [31:0] ADDR_PDM_HI = 32'h4013_1fff;
	localparam logic [31:0] ADDR_PWM_LO = 32'h4016_9400;
	localparam logic [31:0] ADDR_PWM_HI = 32'h4016_9fff;
	localparam logic [31:0] ADDR_CONV_LO = 32'h4017_0000;
	localparam logic [31:0] ADDR_CONV_HI = 32'h4017_2fff;
	localparam logic [31:0] ADDR_QUAD0_LO = 32'h6400_0000;
	localparam logic [31:0] ADDR_QUAD0_HI = 32'h6400_000f;
	localparam logic [31:0] ADDR_QUAD1_LO = 32'h6400_0010;
	localparam logic [31:0] ADDR_QUAD1_HI = 32'h6400_0013;
	localparam logic [31:0] ADDR_QUAD2_LO = 32'h6400_0014;
	localparam logic [31:0] ADDR_QUAD2_HI = 32'h6400_0037;
	localparam logic [31:0] ADDR_QUAD3_LO = 32'h6400_0804;
	localparam logic [31:0] ADDR_QUAD3_HI = 32'h6400_0807;

	// ==========================================================================
	// Cycle counts (EQ: equal clocks, FAST: system clock faster, upper bound)
	// ==========================================================================
	localparam int LAT_W = 6;
	localparam logic [LAT_W-1:0] LAT_MEM_CTRL = 6'h02;
	localparam logic [LAT_W-1:0] LAT_DEBUG = 6'h02;
	localparam logic [LAT_W-1:0] LAT_SYSCTL_LO = 6'h03;
	localparam logic [LAT_W-1:0] LAT_SYSCTL_HI_EQ = 6'h07;
	localparam logic [LAT_W-1:0] LAT_SYSCTL_HI_FAST = 6'h07;
	localparam logic [LAT_W-1:0] LAT_PORT_EQ = 6'h03;
	localparam logic [LAT_W-1:0] LAT_PORT_FAST = 6'h04;
	localparam logic [LAT_W-1:0] LAT_FIXED_SLOW = 6'h03;
	localparam logic [LAT_W-1:0] LAT_LPTIM_RD = 6'h03;
	localparam logic [LAT_W-1:0] LAT_LPTIM_WR_EQ = 6'h05;
	localparam logic [LAT_W-1:0] LAT_LPTIM_WR_FAST = 6'h06;
	localparam logic [LAT_W-1:0] LAT_STD_EQ = 6'h03;
	localparam logic [LAT_W-1:0] LAT_STD_FAST = 6'h04;
	localparam logic [LAT_W-1:0] LAT_PWM_RD_EQ = 6'h06;
	localparam logic [LAT_W-1:0] LAT_PWM_RD_FAST = 6'h07;
	localparam logic [LAT_W-1:0] LAT_PWM_WR_EQ = 6'h04;
	localparam logic [LAT_W-1:0] LAT_PWM_WR_FAST = 6'h05;
	localparam logic [LAT_W-1:0] LAT_QUAD_WR_EQ = 6'h0d;
	localparam logic [LAT_W-1:0] LAT_QUAD0_WR_FAST = 6'h0d;
	localparam logic [LAT_W-1:0] LAT_QUAD2_WR_FAST = 6'h0e;
	localparam logic [LAT_W-1:0] LAT_QUAD3_EQ = 6'h02;
	localparam logic [LAT_W-1:0] LAT_QUAD3_FAST = 6'h03;
	localparam logic [LAT_W-1:0] LAT_WIDTH_EXTRA = 6'h02;
	localparam logic [LAT_W-1:0] LAT_RESERVED = 6'h01;

	// Access size codes on the request port.
	localparam logic [1:0] SIZE_BYTE = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;

	// ==========================================================================
	// Enumerations
	// ==========================================================================
	typedef enum logic [4:0] {
		RG_NONE, RG_MEM_CTRL, RG_DEBUG, RG_SYSCTL_LO, RG_SYSCTL_HI, RG_PORT,
		RG_EVT, RG_SOUND, RG_LPTIM, RG_TEMP, RG_CRC, RG_SERCOM, RG_SERPER,
		RG_I3C, RG_PDM, RG_PWM, RG_CONV, RG_QUAD0, RG_QUAD1, RG_QUAD2, RG_QUAD3
	} pald_region_e;

	typedef enum logic [1:0] {
		UNIT_CORE, UNIT_FAST, UNIT_SLOW
	} pald_unit_e;

	typedef enum logic [1:0] {
		ST_IDLE, ST_RUN
	} pald_state_e;

endpackage

// File: src/pald_tmr_if.sv
/*
 * Carrier between the access sequencer and its wait-cycle timer.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface pald_tmr_if;
	logic load;
	logic [pald_pkg::LAT_W-1:0] load_count;
	pald_pkg::pald_unit_e unit;
	logic grant;
	logic fast_tick;
	logic slow_tick;
	logic expired;

	modport ctrl (output load, output load_count, output unit, output grant,
		output fast_tick, output slow_tick, input expired);
	modport timer (input load, input load_count, input unit, input grant,
		input fast_tick, input slow_tick, output expired);
endinterface

`default_nettype wire

// File: src/pald_wait_timer.sv
/*
 * Wait-cycle timer: counts down a loaded latency in the chosen clock unit.
 * Assumes peripheral clock edges arrive as one-cycle ticks on the system clock.
 */
`timescale 1ns/100ps
`default_nettype none

module pald_wait_timer (
	input wire logic clk_in,
	input wire logic reset_n_in,
	pald_tmr_if.timer tmr
);

	// ==========================================================================
	// Countdown
	// ==========================================================================
	logic [pald_pkg::LAT_W-1:0] count_r;
	logic [pald_pkg::LAT_W-1:0] count_nxt;
	logic unit_tick;
	logic step_w;
	logic last_w;

	// A lost bus grant freezes the count, so contention stretches the access.
	assign unit_tick = (tmr.unit == pald_pkg::UNIT_CORE) ? 1'b1 :
		(tmr.unit == pald_pkg::UNIT_FAST) ? tmr.fast_tick : tmr.slow_tick;
	assign step_w = (count_r != '0) && tmr.grant && unit_tick;
	assign count_nxt = tmr.load ? tmr.load_count :
		step_w ? count_r - {{(pald_pkg::LAT_W-1){1'b0}}, 1'b1} : count_r;
	// The last counted tick ends the access in its own cycle, so a count of N spans N cycles.
	assign last_w = step_w && (count_r == {{(pald_pkg::LAT_W-1){1'b0}}, 1'b1});
	assign tmr.expired = (count_r == '0) || last_w;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

endmodule // pald_wait_timer

`default_nettype wire

// File: verif/pald_decoder_monitor.sv
/* Port checker for the access latency decoder.
   Assumes it is bound to pald_decoder and sees only its ports. */
`timescale 1ns/100ps
`default_nettype none
module pald_decoder_monitor (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic access_req_in,
	input wire logic [31:0] access_addr_in,
	input wire logic bus_grant_in,
	input wire logic quad_bus_busy_in,
	input wire logic access_wait_out,
	input wire logic access_done_out,
	input wire logic access_reserved_out,
	input wire logic [4:0] region_out,
	input wire logic [pald_pkg::LAT_W-1:0] latency_out
);
	// =====
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);
	// An idle sampling point is the only place a request is taken.
	wire take;
	assign take = access_req_in && !access_wait_out && !access_done_out;
	sequence s_take(lo, hi);
		take && bus_grant_in && access_addr_in >= lo && access_addr_in <= hi;
	endsequence
	chk_take_starts: assert property (take |=> access_wait_out || access_done_out)
		else $error("taken request did not start");
	chk_done_pulse: assert property (access_done_out |=> !access_done_out)
		else $error("done longer than one cycle");
	chk_wait_to_done: assert property ($fell(access_wait_out) |-> access_done_out)
		else $error("wait ended without done");
	chk_mem_lat: assert property (s_take(pald_pkg::ADDR_MEM_CTRL_LO, pald_pkg::ADDR_MEM_CTRL_HI)
		|=> latency_out == 6'h02 && region_out == 5'h01) else $error("memory control count wrong");
	chk_debug_time: assert property (s_take(pald_pkg::ADDR_DEBUG_LO, pald_pkg::ADDR_DEBUG_HI)
		##1 bus_grant_in |=> access_done_out) else $error("debug access not two cycles");
	chk_sysctl_time: assert property (s_take(pald_pkg::ADDR_SYSCTL_LO_LO, pald_pkg::ADDR_SYSCTL_LO_HI)
		##1 bus_grant_in [*2] |=> access_done_out) else $error("system control not three cycles");
	chk_reserved_code: assert property (access_reserved_out |-> access_done_out && region_out == 5'h00)
		else $error("reserved answer malformed");
	chk_quad_hold: assert property (access_done_out && latency_out >= 6'h0d |-> !quad_bus_busy_in)
		else $error("open write ended while quad bus busy");
	chk_region_hold: assert property (!take |=> $stable(region_out) && $stable(latency_out))
		else $error("region or count changed mid access");
endmodule // pald_decoder_monitor
bind pald_decoder pald_decoder_monitor u_pald_decoder_monitor (
	.clk_in(clk_in),
	.reset_n_in(reset_n_in),
	.access_req_in(access_req_in),
	.access_addr_in(access_addr_in),
	.bus_grant_in(bus_grant_in),
	.quad_bus_busy_in(quad_bus_busy_in),
	.access_wait_out(access_wait_out),
	.access_done_out(access_done_out),
	.access_reserved_out(access_reserved_out),
	.region_out(region_out),
	.latency_out(latency_out)
);
`default_nettype wire

// File: verif/pald_decoder_tb.sv
/* Self-checking bench for the access latency decoder.
   Assumes the far-side model supplies ticks and the quad busy flag. */
`timescale 1ns/100ps
`default_nettype none
module pald_decoder_tb;
	// =====
	// Stimulus and instances
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic req = 1'b0;
	logic [31:0] addr = 32'h0;
	logic wr = 1'b0;
	logic [1:0] size = 2'h0;
	logic grant = 1'b1;
	logic faster = 1'b0;
	logic [3:0] fdiv = 4'h1;
	logic [3:0] sdiv = 4'h1;
	logic [7:0] blen = 8'h00;
	logic ftick;
	logic stick;
	logic qbusy;
	logic wait_o;
	logic done_o;
	logic rsv_o;
	logic [4:0] rg_o;
	logic [pald_pkg::LAT_W-1:0] lat_o;
	int num_errors = 0;
	int checked = 0;
	always #50 clk_in = ~clk_in;
	pald_decoder u_pald_decoder (.clk_in(clk_in), .reset_n_in(reset_n_in), .access_req_in(req),
		.access_addr_in(addr), .access_write_in(wr), .access_size_in(size), .bus_grant_in(grant),
		.core_faster_in(faster), .fast_tick_in(ftick), .slow_tick_in(stick), .quad_bus_busy_in(qbusy),
		.access_wait_out(wait_o), .access_done_out(done_o), .access_reserved_out(rsv_o),
		.region_out(rg_o), .latency_out(lat_o));
	pald_periph_model u_pald_periph_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .fast_div_in(fdiv),
		.slow_div_in(sdiv), .busy_len_in(blen), .access_req_in(req), .access_write_in(wr),
		.access_addr_in(addr), .fast_tick_out(ftick), .slow_tick_out(stick), .quad_bus_busy_out(qbusy));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One access; n is the cycle after the taking edge in which done shows.
	task automatic do_access(input logic [31:0] a, input logic w, input logic [1:0] s, input logic f, output int n);
		@(posedge clk_in);
		#1;
		req = 1'b1;
		addr = a;
		wr = w;
		size = s;
		faster = f;
		@(posedge clk_in);
		#1;
		req = 1'b0;
		n = 0;
		do begin
			@(negedge clk_in);
			n++;
			if (n > 200) begin
				num_errors++;
				$display("MISMATCH done wait expected 1 seen 0");
				print_verdict();
			end
		end while (done_o !== 1'b1);
	endtask
	task automatic acc_pair(input logic [31:0] a, input logic w, input logic [1:0] s, input int eq, input int fa,
		input int rg);
		int n;
		for (int f = 0; f < 2; f++) begin
			do_access(a, w, s, f[0], n);
			check("cycles", n, f ? fa : eq);
			check("latency", lat_o, f ? fa : eq);
			check("region", rg_o, rg);
		end
	endtask
	task automatic test_table();
		acc_pair(32'h4000_0000, 0, 2, 2, 2, 1);
		acc_pair(32'h4000_6ffc, 1, 2, 2, 2, 1);
		acc_pair(32'h4001_cffc, 0, 2, 2, 2, 2);
		acc_pair(32'h4001_e3fc, 1, 2, 3, 3, 3);
		acc_pair(32'h4001_e400, 0, 2, 7, 7, 4);
		acc_pair(32'h4008_0ffc, 1, 2, 3, 4, 5);
		acc_pair(32'h4008_4000, 0, 2, 3, 3, 6);
		acc_pair(32'h4009_dffc, 1, 2, 3, 3, 7);
		acc_pair(32'h400e_8000, 0, 2, 3, 3, 8);
		acc_pair(32'h400e_8100, 1, 2, 5, 6, 8);
		acc_pair(32'h400f_3000, 1, 2, 3, 4, 9);
		acc_pair(32'h4010_9ffc, 0, 2, 3, 4, 10);
		acc_pair(32'h4011_8000, 0, 0, 3, 4, 11);
		acc_pair(32'h4011_8002, 1, 1, 5, 6, 11);
		acc_pair(32'h4011_a000, 1, 1, 3, 4, 12);
		acc_pair(32'h4011_a004, 0, 2, 5, 6, 12);
		acc_pair(32'h4011_f000, 0, 2, 3, 4, 13);
		acc_pair(32'h4013_1ffc, 1, 2, 3, 4, 14);
		acc_pair(32'h4016_9400, 0, 2, 6, 7, 15);
		acc_pair(32'h4016_9ffc, 1, 2, 4, 5, 15);
		acc_pair(32'h4017_2ffc, 0, 2, 3, 4, 16);
		acc_pair(32'h6400_0000, 0, 2, 3, 4, 17);
		acc_pair(32'h6400_000c, 1, 2, 13, 13, 17);
		acc_pair(32'h6400_0010, 1, 2, 3, 4, 18);
		acc_pair(32'h6400_0034, 0, 2, 3, 4, 19);
		acc_pair(32'h6400_0014, 1, 2, 13, 14, 19);
		acc_pair(32'h6400_0804, 1, 2, 2, 3, 20);
		$display("test_table done");
	endtask
	task automatic test_reserved_b2b();
		int n;
		logic [5:0] v;
		do_access(32'h4000_7000, 0, 2, 0, n);
		check("reserved cycles", n, 1);
		check("reserved flag", {rsv_o, rg_o}, 6'h20);
		do_access(32'h6400_0038, 1, 2, 1, n);
		check("reserved flag", {rsv_o, rg_o}, 6'h20);
		// A held request is taken only at the idle point after each done.
		@(posedge clk_in);
		#1;
		req = 1'b1;
		addr = 32'h4000_3000;
		for (int k = 0; k < 6; k++) begin
			@(negedge clk_in);
			v[k] = done_o;
		end
		@(posedge clk_in);
		#1;
		req = 1'b0;
		check("back to back done", v, 6'h24);
		$display("test_reserved_b2b done");
	endtask
	task automatic test_clocks();
		int n;
		fork
			do_access(32'h4008_0000, 0, 2, 0, n);
			begin
				repeat (2) @(posedge clk_in);
				#1;
				grant = 1'b0;
				repeat (3) @(posedge clk_in);
				#1;
				grant = 1'b1;
			end
		join
		check("grant stretch", n >= 6 && n <= 7, 1);
		sdiv = 4'h3;
		do_access(32'h4001_e400, 0, 2, 0, n);
		check("slow unit", n >= 18 && n <= 22, 1);
		do_access(32'h4010_8000, 0, 2, 0, n);
		check("fast unit", n, 3);
		fdiv = 4'h2;
		do_access(32'h4016_9400, 0, 2, 0, n);
		check("fast divided", n >= 11 && n <= 14, 1);
		fdiv = 4'h1;
		sdiv = 4'h1;
		blen = 8'd20;
		do_access(32'h6400_0000, 1, 2, 0, n);
		check("open write", n >= 21 && n <= 22, 1);
		do_access(32'h6400_0010, 1, 2, 0, n);
		check("closed write", n, 3);
		blen = 8'h00;
		$display("test_clocks done");
	endtask
	task automatic test_reset();
		int n;
		@(posedge clk_in);
		#1;
		req = 1'b1;
		addr = 32'h4001_e400;
		repeat (3) @(posedge clk_in);
		#1;
		req = 1'b0;
		reset_n_in = 1'b0;
		#10;
		check("reset outputs", {wait_o, done_o, rsv_o, rg_o, lat_o}, 0);
		@(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		do_access(32'h4000_0000, 0, 2, 0, n);
		check("after reset", n, 2);
		$display("test_reset done");
	endtask
	initial begin
		repeat (20) @(posedge clk_in);
		#1;
		reset_n_in = 1'b1;
		test_table();
		test_reserved_b2b();
		test_clocks();
		test_reset();
		print_verdict();
	end
endmodule // pald_decoder_tb
`default_nettype wire

// File: verif/pald_periph_model.sv
/* Far-side model: peripheral clock ticks and the quad-serial bus busy flag.
   Assumes one system clock and ticks expressed as one-cycle pulses on it. */
`timescale 1ns/100ps
`default_nettype none
module pald_periph_model (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [3:0] fast_div_in,
	input wire logic [3:0] slow_div_in,
	input wire logic [7:0] busy_len_in,
	input wire logic access_req_in,
	input wire logic access_write_in,
	input wire logic [31:0] access_addr_in,
	output logic fast_tick_out,
	output logic slow_tick_out,
	output logic quad_bus_busy_out
);
	// =====
	// Ticks and busy
	logic [3:0] fast_cnt_r;
	logic [3:0] slow_cnt_r;
	logic [7:0] busy_cnt_r;
	assign fast_tick_out = (fast_cnt_r == 4'h0);
	assign slow_tick_out = (slow_cnt_r == 4'h0);
	assign quad_bus_busy_out = (busy_cnt_r != 8'h00);
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fast_cnt_r <= 4'h0;
			slow_cnt_r <= 4'h0;
			busy_cnt_r <= 8'h00;
		end else begin
			fast_cnt_r <= (fast_cnt_r + 4'h1 >= fast_div_in) ? 4'h0 : fast_cnt_r + 4'h1;
			slow_cnt_r <= (slow_cnt_r + 4'h1 >= slow_div_in) ? 4'h0 : slow_cnt_r + 4'h1;
			// Any quad-window write starts a bus cycle of the set length.
			if (access_req_in && access_write_in && access_addr_in[31:24] == 8'h64) begin
				busy_cnt_r <= busy_len_in;
			end else if (busy_cnt_r != 8'h00) begin
				busy_cnt_r <= busy_cnt_r - 8'h01;
			end
		end
	end
endmodule // pald_periph_model
`default_nettype wire
